// ==== rtir_pkg.sv ====
// package: register map, field layout and timing constants of the rtc interrupt and rate logic
// Function
// R1: summary flag set by any enabled event flag
// R2: interrupt line low exactly while summary set
// R3: periodic flag set on selected divider tap edge
// R4: alarm flag set on alarm time match
// R5: update flag set after each update cycle
// R6: event flags set regardless of enables
// R7: reading flag register clears all flags
// R8: reset clears summary and event flags
// R9: flags stable during read, late events deferred
// R10: flag register low nibble reads zero
// R11: enabling over pending flag raises interrupt immediately
// R12: host clears stale flags before enabling
// R13: host examines every flag per read
// R14: backup valid bit read-only, reset-immune
// R15: backup status low seven bits read zero
// R16: year rollover loads century, keeps MSB
// R17: general RAM always accessible by host
// R18: oscillator control codes run, hold, stop
// R19: thirteen divider taps feed one shared selector
// R20: rate code decodes to documented periods
// R21: square wave, periodic interrupt enabled separately
// R22: square wave pin low when disabled
// R23: reset clears interrupt enable bits
// R24: first update 500ms after run code
// R25: square wave roughly fifty percent duty
package rtir_pkg;

    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL_A = 7'h0A;
    localparam logic [ADDR_W-1:0] REG_CTRL_B = 7'h0B;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 7'h0C;
    localparam logic [ADDR_W-1:0] REG_BACKUP = 7'h0D;
    localparam logic [ADDR_W-1:0] REG_CENTURY = 7'h32;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int A_UIP = 7;
    localparam int A_DV_MSB = 6;
    localparam int A_DV_LSB = 4;
    localparam int A_RS_MSB = 3;
    localparam int A_RS_LSB = 0;
    localparam int B_SET = 7;
    localparam int B_EN_MSB = 6;
    localparam int B_EN_LSB = 4;
    localparam int B_UIE = 4;
    localparam int B_SQUARE_WAVE_ENABLE = 3;
    localparam int B_DM = 2;
    localparam int B_HR24 = 1;
    localparam int B_DSE = 0;
    localparam int CENT_MSB = 7;
    localparam logic [6:0] CENT_LOAD = 7'h20;
    localparam logic [3:0] FLAG_LOW_ZERO = 4'h0;
    localparam logic [6:0] BACKUP_LOW_ZERO = 7'h00;

    // ************************************************************
    // oscillator control codes and divider
    // ************************************************************
    localparam logic [2:0] OSC_RUN = 3'h2;
    localparam logic [1:0] OSC_HOLD_HI = 2'h3;
    localparam int DIV_W = 15;
    localparam int UPD_BIT = 14;
    localparam logic [3:0] RATE_NONE = 4'h0;
    localparam logic [3:0] RATE_ALIAS1 = 4'h1;
    localparam logic [3:0] RATE_ALIAS2 = 4'h2;
    localparam logic [3:0] TAP_ALIAS1 = 4'h6;
    localparam logic [3:0] TAP_ALIAS2 = 4'h7;
    localparam logic [3:0] TAP_OFFSET = 4'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_HZ = 200_000_000;
    localparam longint OSC_HZ = 32_768;
    localparam int OSC_DIV_DEF = int'(CLK_HZ / OSC_HZ);

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rtir_bus_req_t;

    typedef struct packed {
        logic alarm_match;
        logic update_done;
        logic year_rollover;
        logic update_busy;
    } rtir_evt_t;

    typedef struct packed {
        logic set_mode;
        logic data_binary;
        logic hour24;
        logic dst_enable;
    } rtir_mode_t;

    // rate code to divider bit; codes 1 and 2 alias two slow taps
    function automatic logic [3:0] rtir_tap(input logic [3:0] rs);
        logic [3:0] idx;
        idx = rs - TAP_OFFSET;
        if (rs == RATE_ALIAS1) begin
            idx = TAP_ALIAS1;
        end else if (rs == RATE_ALIAS2) begin
            idx = TAP_ALIAS2;
        end
        return idx;
    endfunction

endpackage

// ==== rtir_core.sv ====
// module: interrupt flags, rate selector, square wave, century load and host registers of the rtc
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none

module rtir_core
    import rtir_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire rtir_bus_req_t bus_req,
    output logic [DATA_W-1:0] rd_data,
    input wire rtir_evt_t evt,
    input wire logic backup_ok_pin,
    output logic irq_n,
    output logic sqw_out,
    output logic update_tick,
    output rtir_mode_t mode
);

    localparam int PRE_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_DIV - 1);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (OSC_DIV < 2) begin : g_bad_div
            $error("OSC_DIV must be at least 2");
        end
    endgenerate

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    // two flops release the reset on a clock edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ************************************************************
    // register state
    // ************************************************************
    logic [DATA_W-1:0] ctrl_a_ff;
    logic [DATA_W-1:0] ctrl_b_ff;
    logic [2:0] flags_ff;
    logic [2:0] pend_ff;
    logic summary_ff;
    logic irq_n_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] century_ff;
    logic [DATA_W-1:0] ram_ff [0:(1<<ADDR_W)-1];
    logic bv_meta_ff;
    logic bv_sync_ff;
    logic [PRE_W-1:0] pre_ff;
    logic osc_tick_ff;
    logic [DIV_W-1:0] div_ff;
    logic tap_prev_ff;
    logic sqw_ff;
    logic upd_tick_ff;

    // ************************************************************
    // address decode
    // ************************************************************
    wire sel_a = bus_req.addr == REG_CTRL_A;
    wire sel_b = bus_req.addr == REG_CTRL_B;
    wire sel_c = bus_req.addr == REG_FLAGS;
    wire sel_d = bus_req.addr == REG_BACKUP;
    wire sel_cent = bus_req.addr == REG_CENTURY;
    wire sel_ram = !(sel_a || sel_b || sel_c || sel_d || sel_cent);
    wire wr_a = bus_req.wr && sel_a;
    wire wr_b = bus_req.wr && sel_b;
    wire wr_cent = bus_req.wr && sel_cent;
    wire wr_ram = bus_req.wr && sel_ram;
    wire rd_c = bus_req.rd && sel_c;

    // ************************************************************
    // oscillator control and divider chain
    // ************************************************************
    wire [2:0] osc_code = ctrl_a_ff[A_DV_MSB:A_DV_LSB];
    wire osc_run = osc_code == OSC_RUN;
    wire chain_hold = osc_code[2:1] == OSC_HOLD_HI;
    wire osc_on = osc_run || chain_hold; // R18
    wire enter_run = wr_a && (bus_req.wdata[A_DV_MSB:A_DV_LSB] == OSC_RUN) && !osc_run;
    wire pre_wrap = pre_ff == PRE_LAST;
    wire [PRE_W-1:0] nxt_pre = (!osc_on || pre_wrap) ? '0 : pre_ff + 1'b1;
    wire nxt_osc_tick = osc_on && pre_wrap;
    // chain cleared on hold or on entering run, so the first update lands half a second later
    wire [DIV_W-1:0] nxt_div = (chain_hold || enter_run) ? '0 : // R18 R24
        (osc_run && osc_tick_ff) ? div_ff + 1'b1 : div_ff;
    wire nxt_upd_tick = nxt_div[UPD_BIT] && !div_ff[UPD_BIT]; // R24

    // prescaler makes the 32 kHz enable, chain counts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= '0;
            osc_tick_ff <= 1'b0;
            div_ff <= '0;
            upd_tick_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            osc_tick_ff <= nxt_osc_tick;
            div_ff <= nxt_div;
            upd_tick_ff <= nxt_upd_tick;
        end
    end

    // ************************************************************
    // rate selector shared by square wave and periodic flag
    // ************************************************************
    wire [3:0] rate_sel = ctrl_a_ff[A_RS_MSB:A_RS_LSB];
    wire rate_on = rate_sel != RATE_NONE; // R20
    wire [3:0] tap_idx = rtir_tap(rate_sel); // R19 R20
    wire tap_bit = rate_on && div_ff[tap_idx]; // R19
    wire per_evt = tap_bit && !tap_prev_ff; // R3
    // divider bit already has even duty, so the pin just follows it
    wire nxt_sqw = ctrl_b_ff[B_SQUARE_WAVE_ENABLE] && tap_bit; // R21 R22 R25

    // tap history and square wave pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_prev_ff <= 1'b0;
            sqw_ff <= 1'b0;
        end else begin
            tap_prev_ff <= tap_bit;
            sqw_ff <= nxt_sqw;
        end
    end

    // ************************************************************
    // flags, summary and interrupt line
    // ************************************************************
    wire [2:0] evt_vec = {per_evt, evt.alarm_match, evt.update_done}; // R4 R5 R6
    // a read snapshots then clears; events in a read cycle wait in pend until a cycle without a read
    // pend keeps its content over back-to-back reads, otherwise a second read would drop it
    wire [2:0] nxt_flags = rd_c ? 3'h0 : (flags_ff | evt_vec | pend_ff); // R7 R9
    wire [2:0] nxt_pend = rd_c ? (evt_vec | pend_ff) : 3'h0; // R9
    wire nxt_uie = bus_req.wdata[B_UIE] && !bus_req.wdata[B_SET];
    wire [DATA_W-1:0] b_wval = {bus_req.wdata[7:5], nxt_uie, bus_req.wdata[3:0]};
    wire [DATA_W-1:0] nxt_ctrl_b = wr_b ? b_wval : ctrl_b_ff;
    wire [2:0] nxt_en = nxt_ctrl_b[B_EN_MSB:B_EN_LSB];
    wire nxt_summary = |(nxt_flags & nxt_en); // R1 R11
    wire [DATA_W-1:0] nxt_ctrl_a = wr_a ? {1'b0, bus_req.wdata[6:0]} : ctrl_a_ff;

    // control registers and flag latches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_ff <= DATA_ZERO;
            ctrl_b_ff <= DATA_ZERO; // R23
            flags_ff <= 3'h0; // R8
            pend_ff <= 3'h0;
            summary_ff <= 1'b0; // R8
            irq_n_ff <= 1'b1;
        end else begin
            ctrl_a_ff <= nxt_ctrl_a;
            ctrl_b_ff <= nxt_ctrl_b;
            flags_ff <= nxt_flags;
            pend_ff <= nxt_pend;
            summary_ff <= nxt_summary;
            irq_n_ff <= !nxt_summary; // R2
        end
    end

    // ************************************************************
    // backup valid input, never reset
    // ************************************************************
    always_ff @(posedge clk) begin
        bv_meta_ff <= backup_ok_pin;
        bv_sync_ff <= bv_meta_ff; // R14
    end

    // ************************************************************
    // century byte and general ram
    // ************************************************************
    // rollover load wins; its msb keeps whatever the host wrote
    always_ff @(posedge clk) begin
        if (evt.year_rollover) begin
            century_ff <= {century_ff[CENT_MSB], CENT_LOAD}; // R16
        end else if (wr_cent) begin
            century_ff <= bus_req.wdata;
        end
        if (wr_ram) begin
            ram_ff[bus_req.addr] <= bus_req.wdata; // R17
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    wire [DATA_W-1:0] view_a = {evt.update_busy, ctrl_a_ff[6:0]};
    wire [DATA_W-1:0] view_c = {summary_ff, flags_ff, FLAG_LOW_ZERO}; // R10
    wire [DATA_W-1:0] view_d = {bv_sync_ff, BACKUP_LOW_ZERO}; // R14 R15
    wire [DATA_W-1:0] rd_mux = sel_a ? view_a :
        sel_b ? ctrl_b_ff :
        sel_c ? view_c :
        sel_d ? view_d :
        sel_cent ? century_ff : ram_ff[bus_req.addr];
    wire [DATA_W-1:0] nxt_rd_data = bus_req.rd ? rd_mux : DATA_ZERO;

    // read data stands one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= DATA_ZERO;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data = rd_data_ff;
    assign irq_n = irq_n_ff;
    assign sqw_out = sqw_ff;
    assign update_tick = upd_tick_ff;
    assign mode = '{set_mode: ctrl_b_ff[B_SET], data_binary: ctrl_b_ff[B_DM],
                    hour24: ctrl_b_ff[B_HR24], dst_enable: ctrl_b_ff[B_DSE]};

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_irq_pin_follows: assert property (irq_n_ff == !summary_ff) // R2
        else $error("interrupt line disagrees with summary flag");
    chk_summary_cause: assert property (summary_ff == |(flags_ff & ctrl_b_ff[B_EN_MSB:B_EN_LSB])) // R1
        else $error("summary flag not the or of enabled flags");
    chk_read_clears: assert property (rd_c |=> (flags_ff == 3'h0) && !summary_ff && irq_n_ff) // R7
        else $error("flag read did not clear flags");
    chk_read_snapshot: assert property (rd_c |=> rd_data_ff == {$past(summary_ff), $past(flags_ff), 4'h0}) // R9
        else $error("flag read data not the pre-clear value");
    chk_deferred_event: assert property (rd_c && evt.alarm_match ##1 !rd_c |=> flags_ff[1]) // R9
        else $error("alarm during flag read was lost");
    chk_alarm_sets: assert property (!rd_c && evt.alarm_match |=> flags_ff[1]) // R4
        else $error("alarm event did not set flag");
    chk_update_sets: assert property (!rd_c && evt.update_done && !wr_b |=> flags_ff[0]) // R5
        else $error("update event did not set flag");
    chk_enable_raises: assert property (wr_b && bus_req.wdata[B_EN_MSB] && flags_ff[2] && !rd_c |=> !irq_n_ff) // R11
        else $error("enable over set flag did not raise interrupt");
    chk_sqw_low: assert property (!ctrl_b_ff[B_SQUARE_WAVE_ENABLE] |=> !sqw_ff) // R22
        else $error("square wave active while disabled");
    chk_chain_hold: assert property (chain_hold |=> div_ff == '0) // R18
        else $error("divider chain ran while held");
    chk_century_load: assert property (evt.year_rollover |=>
        century_ff[6:0] == CENT_LOAD && century_ff[CENT_MSB] == $past(century_ff[CENT_MSB])) // R16
        else $error("century load wrong after year rollover");
    chk_backup_low: assert property (bus_req.rd && sel_d |=> rd_data_ff[6:0] == 7'h00) // R15
        else $error("backup status low bits not zero");

    cov_periodic: cover property (per_evt && ctrl_b_ff[B_EN_MSB] ##1 !irq_n_ff);
    cov_read_event: cover property (rd_c && evt.update_done);
    cov_update_tick: cover property (osc_run && upd_tick_ff);
    cov_sqw_toggle: cover property (sqw_ff ##1 !sqw_ff);

endmodule

`default_nettype wire

// ==== rtir_time_model.sv ====
// time-logic stand-in: turns bench requests into one-cycle event pulses
`timescale 1ns/100ps
`default_nettype none

module rtir_time_model
    import rtir_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] fire,
    input wire logic busy,
    output rtir_evt_t evt
);
    // ************************************************************
    // event pulses
    // ************************************************************
    logic [3:0] evt_ff = 4'h0;

    // one pulse per request cycle, one clock late like the real counter logic
    always @(posedge clk) begin
        evt_ff <= {fire, busy};
    end
    assign evt = evt_ff;
endmodule

`default_nettype wire

// ==== rtc_interrupt_rate_logic_bench.sv ====
// testbench: registers, flags, interrupt line and rate outputs of the rtc interrupt block
`timescale 1ns/100ps
`default_nettype none

module rtc_interrupt_rate_logic_bench
    import rtir_pkg::*;
;
    localparam int DIVS = 2;
    localparam logic [2:0] ALM = 3'h4;
    localparam logic [2:0] UPD = 3'h2;
    localparam logic [2:0] ROL = 3'h1;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic backup_ok_pin = 1'b1;
    logic [2:0] fire = 3'h0;
    logic busy = 1'b0;
    rtir_bus_req_t bus_req = '0;
    logic [DATA_W-1:0] rd_data;
    rtir_evt_t evt;
    logic irq_n;
    logic sqw_out;
    logic update_tick;
    rtir_mode_t mode;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [7:0] v;
    logic [6:0] a;
    logic ok;
    int n;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    rtir_core #(.OSC_DIV(DIVS)) dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
        .evt(evt), .backup_ok_pin(backup_ok_pin), .irq_n(irq_n), .sqw_out(sqw_out),
        .update_tick(update_tick), .mode(mode));
    rtir_time_model tm (.clk(clk), .fire(fire), .busy(busy), .evt(evt));

    // ************************************************************
    // bus, compare and closing tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (e !== s) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask

    task automatic wr(input logic [6:0] ad, input logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= ad;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // the expected byte is queued; the monitor below takes it off
    task automatic rd(input logic [6:0] ad, input logic [7:0] e);
        @(posedge clk);
        bus_req.addr <= ad;
        bus_req.rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask

    task automatic pulse(input logic [2:0] k);
        @(posedge clk);
        fire <= k;
        @(posedge clk);
        fire <= 3'h0;
    endtask

    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask

    function automatic int exp_per(input logic [3:0] c);
        int tp;
        tp = (c == 4'h1) ? 6 : (c == 4'h2) ? 7 : int'(c) - 2;
        return DIVS << (tp + 1);
    endfunction

    // period and high time between the 2nd and 3rd rising edge
    task automatic sq(input logic [3:0] c);
        int t[3];
        int k;
        int hi;
        logic p;
        k = 0;
        hi = 0;
        p = 1'b1;
        wr(REG_CTRL_A, {4'h2, c});
        for (int i = 0; i < 20000 && k < 3; i++) begin
            @(negedge clk);
            if (sqw_out === 1'b1 && p === 1'b0) begin
                t[k] = i;
                k++;
            end
            if (k == 2 && sqw_out === 1'b1) hi++;
            p = sqw_out;
        end
        chk("square_wave_out period", 32'(exp_per(c)), 32'(t[2] - t[1]));
        chk("square_wave_out high time", 32'(exp_per(c) / 2), 32'(hi));
    endtask

    task automatic low64(input logic [7:0] av, input logic [7:0] bv);
        logic hi;
        hi = 1'b0;
        wr(REG_CTRL_A, av);
        wr(REG_CTRL_B, bv);
        repeat (64) begin
            @(negedge clk);
            hi |= sqw_out;
        end
        chk("square_wave_out low", 1'b0, hi);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, zero otherwise
    always @(negedge clk) begin
        if (rd_seen) begin
            chk("rd_data", exp_q.pop_front(), rd_data);
        end else if (reset_n && rd_data !== DATA_ZERO) begin
            chk("rd_data idle", DATA_ZERO, rd_data);
        end
        rd_seen = bus_req.rd;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h0000_8b28));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        tick(4);
        rd(REG_CTRL_B, 8'h00);
        rd(REG_FLAGS, 8'h00);
        wr(REG_BACKUP, 8'h7f);
        wr(REG_FLAGS, 8'hff);
        rd(REG_BACKUP, 8'h80);
        rd(REG_FLAGS, 8'h00);
        backup_ok_pin <= 1'b0;
        tick(4);
        rd(REG_BACKUP, 8'h00);
        backup_ok_pin <= 1'b1;
        $display("test status registers done");
        // polled flags, clear on read, enable over a pending flag
        pulse(ALM);
        pulse(UPD);
        tick(2);
        chk("irq_n", 1'b1, irq_n);
        rd(REG_FLAGS, 8'h30);
        rd(REG_FLAGS, 8'h00);
        pulse(ALM);
        tick(2);
        wr(REG_CTRL_B, 8'h20);
        @(negedge clk);
        chk("irq_n", 1'b0, irq_n);
        rd(REG_FLAGS, 8'ha0);
        @(negedge clk);
        chk("irq_n", 1'b1, irq_n);
        rd(REG_FLAGS, 8'h00);
        wr(REG_CTRL_B, 8'h10);
        pulse(UPD);
        tick(2);
        chk("irq_n", 1'b0, irq_n);
        fork
            pulse(ALM);
            begin
                @(posedge clk);
                rd(REG_FLAGS, 8'h90);
            end
        join
        tick(2);
        rd(REG_FLAGS, 8'h20);
        $display("test flags done");
        // century load, general bytes, mode copies
        v = 8'($urandom);
        wr(REG_CENTURY, {1'b1, v[6:0]});
        pulse(ROL);
        tick(2);
        rd(REG_CENTURY, {1'b1, CENT_LOAD});
        wr(REG_CENTURY, {1'b0, v[6:0]});
        pulse(ROL);
        tick(2);
        rd(REG_CENTURY, {1'b0, CENT_LOAD});
        busy <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = 7'h0e + 7'($urandom % 36);
            v = 8'($urandom);
            wr(a, v);
            rd(a, v);
        end
        rd(REG_CTRL_A, 8'h80);
        wr(REG_CTRL_B, 8'h87);
        tick(2);
        chk("mode", 4'hf, mode);
        $display("test century and storage done");
        // rate selector on the square wave, then on the periodic flag
        wr(REG_CTRL_B, 8'h08);
        for (int c = 1; c < 12; c++) begin
            sq(4'(c));
        end
        chk("irq_n", 1'b1, irq_n);
        wr(REG_CTRL_B, 8'h48);
        @(negedge clk);
        chk("irq_n", 1'b0, irq_n);
        rd(REG_FLAGS, 8'hc0);
        low64(8'h20, 8'h08);
        low64(8'h23, 8'h00);
        low64(8'h63, 8'h08);
        $display("test rates done");
        // first update after the run code
        wr(REG_CTRL_A, 8'h00);
        wr(REG_CTRL_A, 8'h20);
        n = 0;
        while (update_tick !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        ok = (n >= DIVS * 16384 - 6) && (n <= DIVS * 16384 + 6);
        chk("update_tick delay", 1'b1, ok);
        $display("test update start done");
        // reset in mid-run clears flags and enables, not the backup bit
        pulse(ALM);
        wr(REG_CTRL_B, 8'h20);
        @(posedge clk);
        reset_n <= 1'b0;
        tick(2);
        chk("irq_n", 1'b1, irq_n);
        @(posedge clk);
        reset_n <= 1'b1;
        tick(4);
        rd(REG_FLAGS, 8'h00);
        rd(REG_CTRL_B, 8'h00);
        rd(REG_BACKUP, 8'h80);
        tick(2);
        $display("test reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
